/* serial_link_pkg.sv */
// package: register map, field positions, timing, carrier types and helpers of the serial link
// Function
// - transmitter pops FIFO words into a shifter and sends them lsb first
// - each 16-bit word is followed by one parity bit, odd or even by setting
// - a transmitted message is one or two words, per word-length mode
// - FIFO words wait until software sets the transmit start control
// - serial clock idles high, pulses only in transfers; data valid at rising edge
// - each bit period is four reference ticks: three high, one low
// - transmit data changes half a bit period away from the rising edge
// - receiver waits until the clock stayed high longer than the gap setting
// - after a gap each low-to-high clock transition shifts in one data bit
// - after 17 edges the word is latched, parity checked, stored in the FIFO
// - in 32-bit mode the second word follows with no new gap
// - a complete message raises a maskable request and returns to idle
// - receive start clears at message end unless continuous reception is chosen
// - in continuous mode the receiver re-arms and hunts for a new gap
// - every word the receiver stores in the receive FIFO checks for over-run; host loop-back writes do not
// - parity and over-run errors stay set until software clears them
// - four maskable interrupt sources plus a software-written vector
// - answers id, interrupt acknowledge, memory and io selects; dma lines idle
// - every host access gets inserted wait states; host hold cycles are honoured
// - read data stays driven until the host releases its select
// - a write ends on local timing while the select is still asserted
// - two 1K x 16 FIFOs plus host loop-back ports into and out of them
// - transmit start clears itself when the message is finished
package serial_link_pkg;
    localparam logic [6:0] OFS_TX_CTRL = 7'h00;
    localparam logic [6:0] OFS_RX_CTRL = 7'h02;
    localparam logic [6:0] OFS_DIV = 7'h04;
    localparam logic [6:0] OFS_VECTOR = 7'h06;
    localparam logic [6:0] OFS_STAT0 = 7'h08;
    localparam logic [6:0] OFS_STAT1 = 7'h0a;
    localparam logic [6:0] OFS_TX_FIFO = 7'h10;
    localparam logic [6:0] OFS_WORD_CTRL = 7'h16;
    localparam logic [6:0] OFS_GAP = 7'h1e;
    localparam logic [6:0] OFS_RX_LOOP = 7'h20;
    localparam logic [6:0] OFS_TX_LOOP = 7'h22;
    localparam logic [6:0] OFS_RX_FIFO = 7'h40;
    localparam int TXC_START = 0, TXC_IEN_TX = 1, TXC_IEN_FAE = 2, TXC_FORCE = 3;
    localparam int TXC_MODE32 = 5, TXC_ODD = 6;
    localparam int RXC_START = 0, RXC_IEN_RX = 1, RXC_IEN_FAF = 2, RXC_AUTOCLR = 4;
    localparam int RXC_MODE32 = 5, RXC_ODD = 6, RXC_FIFO_EN = 7;
    localparam int STS_TX = 0, STS_RX = 1, STS_FAE = 2, STS_FAF = 3, STS_PAR = 4, STS_OVR = 5;
    localparam int WC_MASTER = 15;
    localparam logic [10:0] FIFO_DEPTH = 11'h400;
    localparam logic [4:0] WORD_BITS = 5'h11;
    localparam logic [15:0] GAP_RESET = 16'h0100;
    localparam logic [15:0] WORD_CTRL_RESET = 16'h0010;
    localparam logic [15:0] ID_WORD = 16'h5a5a; // arbitrary identification value
    localparam int BIT_PERIOD_US = 16;
    localparam int SETUP_US = 8;
    localparam int REF_PER_BIT = 4;
    localparam logic [1:0] PH_DATA = 2'(SETUP_US * REF_PER_BIT / BIT_PERIOD_US);
    localparam logic [1:0] PH_LOW = 2'(REF_PER_BIT - 1);
    localparam logic [1:0] WAIT_LAST = 2'h1;

    typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_WAIT = 2'b01, BUS_HOLD = 2'b10} bus_state_t;
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_GAP = 2'b01, RX_BITS = 2'b10} rx_state_t;
    typedef struct packed {
        logic io_sel_n;
        logic id_sel_n;
        logic mem_sel_n;
        logic int_sel_n;
        logic write_n;
        logic [1:0] byte_sel_n;
        logic [5:0] addr;
        logic [15:0] wdata;
    } ip_bus_in_t;
    typedef struct packed {
        logic [15:0] rdata;
        logic data_oe;
        logic ack_n;
        logic int_req_n;
        logic dma_req_n;
    } ip_bus_out_t;
    typedef struct packed {
        logic ser_clk;
        logic ser_data;
    } serial_out_t;
    typedef struct packed {
        logic [9:0] pad;
        logic rx_af;
        logic rx_full;
        logic rx_empty;
        logic tx_ae;
        logic tx_full;
        logic tx_empty;
    } fifo_status_t;

    function automatic logic parity_bit(input logic [15:0] d, input logic odd);
        return odd ? ~^d : ^d;
    endfunction
    function automatic logic [1:0] gray_to_bin(input logic [1:0] g);
        return {g[1], g[1] ^ g[0]};
    endfunction
    function automatic logic [1:0] gray_inc(input logic [1:0] g);
        logic [1:0] b;
        b = gray_to_bin(g) + 2'h1;
        return b ^ {1'b0, b[1]};
    endfunction
    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
                                               input logic [1:0] be_n);
        return {be_n[1] ? old[15:8] : nw[15:8], be_n[0] ? old[7:0] : nw[7:0]};
    endfunction
endpackage

/* gated_clock_serial_link.sv */
// gated clock serial link: host bus slave, FIFOs, transmitter and gap-seeking receiver
`timescale 1ns/10ps
module gated_clock_serial_link import serial_link_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    input wire ip_bus_in_t bus_in,
    output ip_bus_out_t bus_out,
    input wire logic rx_link_clock,
    input wire logic rx_data,
    output serial_out_t ser_out
);
    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        logic [1:0] wr_gray;
        logic [3:0] ring;
    } link_state_t;
    typedef struct packed {
        logic [7:0] tx_ctrl;
        logic [7:0] rx_ctrl;
        logic [7:0] div;
        logic [7:0] vector;
        logic [7:0] status;
        logic [15:0] word_ctrl;
        logic [15:0] gap;
        logic [9:0] tx_wr;
        logic [9:0] tx_rd;
        logic [10:0] tx_cnt;
        logic [9:0] rx_wr;
        logic [9:0] rx_rd;
        logic [10:0] rx_cnt;
        bus_state_t bus;
        logic [1:0] bus_wait;
        logic [15:0] rdata;
        logic oe;
        logic ack;
        logic int_req;
        logic fae_d;
        logic faf_d;
        tx_state_t tx;
        logic [7:0] ref_cnt;
        logic [1:0] phase;
        logic [16:0] tx_sh;
        logic [4:0] tx_bits;
        logic tx_second;
        logic ser_clk;
        logic ser_data;
        logic [1:0] wr_meta;
        logic [1:0] wr_sync;
        logic lvl_meta;
        logic lvl_sync;
        logic [1:0] rd_gray;
        rx_state_t rx;
        logic [15:0] gap_cnt;
        logic [16:0] rx_sh;
        logic [4:0] rx_bits;
        logic rx_second;
    } main_state_t;

    link_state_t lk, next_lk;
    main_state_t st, next_st;
    logic [15:0] mem_tx [0:1023];
    logic [15:0] mem_rx [0:1023];
    logic sel, fifo_en, have_bit, tx_w, tx_r, rx_w, rx_r;
    logic tx_push, tx_pop, rx_push, rx_pop, ref_tick, emit;
    logic [15:0] rx_push_data, tx_word, rx_word, rd_val;
    logic [16:0] cur, sh_new;
    logic [7:0] stat_clr, ev, en;
    logic [6:0] ofs;
    fifo_status_t fs;

    // link side: only the edge-captured bits, a gray write pointer and the reset synchroniser live here,
    // since the link clock stops between frames and cannot time a gap itself
    always_comb begin
        next_lk = lk;
        next_lk.rst_meta = rst;
        next_lk.rst_sync = lk.rst_meta;
        if (lk.rst_sync) begin
            next_lk.wr_gray = 2'h0;
        end else begin
            next_lk.ring[gray_to_bin(lk.wr_gray)] = rx_data;
            next_lk.wr_gray = gray_inc(lk.wr_gray);
        end
    end

    always_ff @(posedge rx_link_clock) begin
        lk <= next_lk;
    end

    assign sel = !(bus_in.io_sel_n && bus_in.id_sel_n && bus_in.mem_sel_n && bus_in.int_sel_n);
    assign ofs = {bus_in.addr, 1'b0};
    assign fifo_en = st.rx_ctrl[RXC_FIFO_EN];
    assign have_bit = st.rd_gray != st.wr_sync;
    assign tx_word = mem_tx[st.tx_rd];
    assign rx_word = mem_rx[st.rx_rd];
    assign ref_tick = st.ref_cnt == st.div;
    assign fs.pad = '0;
    assign fs.tx_empty = st.tx_cnt == 11'h000;
    assign fs.tx_full = st.tx_cnt == FIFO_DEPTH;
    assign fs.tx_ae = st.tx_cnt <= {1'b0, st.word_ctrl[9:0]};
    assign fs.rx_empty = st.rx_cnt == 11'h000;
    assign fs.rx_full = st.rx_cnt == FIFO_DEPTH;
    assign fs.rx_af = ({1'b0, st.rx_cnt} + {2'b00, st.word_ctrl[9:0]}) >= {1'b0, FIFO_DEPTH};

    always_comb begin
        case (ofs)
            OFS_TX_CTRL: rd_val = {8'h00, st.tx_ctrl};
            OFS_RX_CTRL: rd_val = {8'h00, st.rx_ctrl};
            OFS_DIV: rd_val = {8'h00, st.div};
            OFS_VECTOR: rd_val = {8'h00, st.vector};
            OFS_STAT0: rd_val = fs;
            OFS_STAT1: rd_val = {8'h00, st.status};
            OFS_WORD_CTRL: rd_val = st.word_ctrl;
            OFS_GAP: rd_val = st.gap;
            OFS_TX_LOOP: rd_val = tx_word;
            OFS_RX_FIFO: rd_val = rx_word;
            default: rd_val = 16'h0000;
        endcase
    end

    always_comb begin
        next_st = st;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        rx_push_data = bus_in.wdata;
        stat_clr = 8'h00;
        ev = 8'h00;
        emit = 1'b0;
        cur = st.tx_sh;
        sh_new = {lk.ring[gray_to_bin(st.rd_gray)], st.rx_sh[16:1]};
        next_st.ack = 1'b0;
        next_st.wr_meta = lk.wr_gray;
        next_st.wr_sync = st.wr_meta;
        next_st.lvl_meta = rx_link_clock;
        next_st.lvl_sync = st.lvl_meta;
        // host bus slave; dma lines are never used
        case (st.bus)
            BUS_IDLE: begin
                if (sel) begin
                    next_st.bus = BUS_WAIT;
                    next_st.bus_wait = 2'h0;
                end
            end
            BUS_WAIT: begin
                if (!sel) begin
                    next_st.bus = BUS_IDLE;
                end else if (st.bus_wait != WAIT_LAST) begin
                    next_st.bus_wait = st.bus_wait + 2'h1;
                end else begin
                    next_st.ack = 1'b1;
                    next_st.bus = BUS_HOLD;
                    if (bus_in.write_n) begin
                        next_st.oe = 1'b1;
                        if (!bus_in.id_sel_n) begin
                            next_st.rdata = ID_WORD;
                        end else if (!bus_in.int_sel_n) begin
                            next_st.rdata = {8'h00, st.vector};
                            next_st.int_req = 1'b0;
                        end else if (!bus_in.mem_sel_n) begin
                            next_st.rdata = rx_word;
                            rx_pop = 1'b1;
                        end else begin
                            next_st.rdata = rd_val;
                            rx_pop = ofs == OFS_RX_FIFO;
                            tx_pop = ofs == OFS_TX_LOOP;
                        end
                    end else if (!bus_in.mem_sel_n) begin
                        tx_push = 1'b1;
                    end else if (!bus_in.io_sel_n) begin
                        case (ofs)
                            OFS_TX_CTRL: if (!bus_in.byte_sel_n[0])
                                next_st.tx_ctrl = bus_in.wdata[7:0];
                            OFS_RX_CTRL: if (!bus_in.byte_sel_n[0])
                                next_st.rx_ctrl = bus_in.wdata[7:0];
                            OFS_DIV: if (!bus_in.byte_sel_n[0]) next_st.div = bus_in.wdata[7:0];
                            OFS_VECTOR: if (!bus_in.byte_sel_n[0])
                                next_st.vector = bus_in.wdata[7:0];
                            OFS_STAT1: if (!bus_in.byte_sel_n[0])
                                stat_clr = bus_in.wdata[7:0];
                            OFS_WORD_CTRL: begin
                                next_st.word_ctrl = lane_merge(st.word_ctrl, bus_in.wdata,
                                                               bus_in.byte_sel_n);
                            end
                            OFS_GAP: next_st.gap = lane_merge(st.gap, bus_in.wdata,
                                                              bus_in.byte_sel_n);
                            OFS_TX_FIFO: tx_push = 1'b1;
                            OFS_RX_LOOP: rx_push = 1'b1;
                            default: ;
                        endcase
                    end
                end
            end
            BUS_HOLD: begin
                if (!sel) begin
                    next_st.oe = 1'b0;
                    next_st.bus = BUS_IDLE;
                end
            end
            default: next_st.bus = BUS_IDLE;
        endcase
        next_st.status = st.status & ~stat_clr;

        // transmitter: reference tick divides the bus clock, four ticks per bit
        next_st.ref_cnt = ref_tick ? 8'h00 : st.ref_cnt + 8'h01;
        case (st.tx)
            TX_IDLE: begin
                next_st.ser_clk = 1'b1;
                if (st.tx_ctrl[TXC_START] && fifo_en && !fs.tx_empty
                    && (!st.tx_ctrl[TXC_MODE32] || st.tx_cnt > 11'h001)) begin
                    tx_pop = 1'b1;
                    next_st.tx_sh = {parity_bit(tx_word, st.tx_ctrl[TXC_ODD]), tx_word};
                    next_st.tx_bits = 5'h00;
                    next_st.tx_second = 1'b0;
                    next_st.phase = PH_DATA - 2'h1;
                    next_st.tx = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (ref_tick) begin
                    next_st.phase = st.phase + 2'h1;
                    next_st.ser_clk = next_st.phase != PH_LOW;
                    if (next_st.phase == PH_DATA) begin
                        if (st.tx_bits != WORD_BITS) begin
                            emit = 1'b1;
                            next_st.tx_bits = st.tx_bits + 5'h01;
                        end else if (st.tx_ctrl[TXC_MODE32] && !st.tx_second && !fs.tx_empty) begin
                            tx_pop = 1'b1;
                            cur = {parity_bit(tx_word, st.tx_ctrl[TXC_ODD]), tx_word};
                            emit = 1'b1;
                            next_st.tx_second = 1'b1;
                            next_st.tx_bits = 5'h01;
                        end else begin
                            next_st.tx = TX_IDLE;
                            next_st.ser_clk = 1'b1;
                            next_st.tx_ctrl[TXC_START] = 1'b0;
                            ev[STS_TX] = 1'b1;
                        end
                        if (emit) begin
                            next_st.ser_data = cur[0];
                            next_st.tx_sh = cur >> 1;
                        end
                    end
                end
            end
            default: next_st.tx = TX_IDLE;
        endcase

        // receiver: one captured bit is drained per cycle from the crossing ring
        if (have_bit) begin
            next_st.rd_gray = gray_inc(st.rd_gray);
        end
        case (st.rx)
            RX_IDLE: begin
                if (st.rx_ctrl[RXC_START]) begin
                    next_st.rx = RX_GAP;
                    next_st.gap_cnt = 16'h0000;
                end
            end
            RX_GAP: begin
                if (!st.rx_ctrl[RXC_START]) begin
                    next_st.rx = RX_IDLE;
                end else if (have_bit || !st.lvl_sync) begin
                    next_st.gap_cnt = 16'h0000;
                end else if (st.gap_cnt > st.gap) begin
                    next_st.rx = RX_BITS;
                    next_st.rx_bits = 5'h00;
                    next_st.rx_second = 1'b0;
                end else begin
                    next_st.gap_cnt = st.gap_cnt + 16'h0001;
                end
            end
            RX_BITS: begin
                if (have_bit) begin
                    next_st.rx_sh = sh_new;
                    next_st.rx_bits = st.rx_bits + 5'h01;
                    if (next_st.rx_bits == WORD_BITS) begin
                        rx_push = 1'b1;
                        rx_push_data = sh_new[15:0];
                        if (sh_new[16] != parity_bit(sh_new[15:0], st.rx_ctrl[RXC_ODD])) begin
                            ev[STS_PAR] = 1'b1;
                        end
                        if (fs.rx_full) begin
                            ev[STS_OVR] = 1'b1;
                        end
                        if (st.rx_ctrl[RXC_MODE32] && !st.rx_second) begin
                            next_st.rx_second = 1'b1;
                            next_st.rx_bits = 5'h00;
                        end else begin
                            ev[STS_RX] = 1'b1;
                            next_st.rx = RX_IDLE;
                            if (st.rx_ctrl[RXC_AUTOCLR]) begin
                                next_st.rx_ctrl[RXC_START] = 1'b0;
                            end
                        end
                    end
                end
            end
            default: next_st.rx = RX_IDLE;
        endcase

        // FIFO pointers; a disabled FIFO is held empty, which is also its reset
        tx_w = tx_push && fifo_en && !fs.tx_full;
        tx_r = tx_pop && fifo_en && !fs.tx_empty;
        rx_w = rx_push && fifo_en && !fs.rx_full;
        rx_r = rx_pop && fifo_en && !fs.rx_empty;
        next_st.tx_wr = st.tx_wr + {9'h000, tx_w};
        next_st.tx_rd = st.tx_rd + {9'h000, tx_r};
        next_st.tx_cnt = st.tx_cnt + {10'h000, tx_w} - {10'h000, tx_r};
        next_st.rx_wr = st.rx_wr + {9'h000, rx_w};
        next_st.rx_rd = st.rx_rd + {9'h000, rx_r};
        next_st.rx_cnt = st.rx_cnt + {10'h000, rx_w} - {10'h000, rx_r};
        if (!fifo_en) begin
            next_st.tx_wr = 10'h000;
            next_st.tx_rd = 10'h000;
            next_st.tx_cnt = 11'h000;
            next_st.rx_wr = 10'h000;
            next_st.rx_rd = 10'h000;
            next_st.rx_cnt = 11'h000;
        end

        // level-type sources fire once on entering the almost condition
        next_st.fae_d = fs.tx_ae;
        next_st.faf_d = fs.rx_af;
        ev[STS_FAE] = fs.tx_ae && !st.fae_d;
        ev[STS_FAF] = fs.rx_af && !st.faf_d;
        en = 8'h00;
        en[STS_TX] = st.tx_ctrl[TXC_IEN_TX];
        en[STS_RX] = st.rx_ctrl[RXC_IEN_RX];
        en[STS_FAE] = st.tx_ctrl[TXC_IEN_FAE];
        en[STS_FAF] = st.rx_ctrl[RXC_IEN_FAF];
        next_st.status = next_st.status | ev;
        next_st.int_req = (next_st.int_req || |(ev & en)) && |(next_st.status & en);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
            st.ser_clk <= 1'b1;
            st.ser_data <= 1'b1;
            st.gap <= GAP_RESET;
            st.word_ctrl <= WORD_CTRL_RESET;
        end else begin
            st <= next_st;
        end
        if (tx_w) begin
            mem_tx[st.tx_wr] <= bus_in.wdata;
        end
        if (rx_w) begin
            mem_rx[st.rx_wr] <= rx_push_data;
        end
    end

    assign bus_out.rdata = st.rdata;
    assign bus_out.data_oe = st.oe;
    assign bus_out.ack_n = !st.ack;
    assign bus_out.int_req_n = !(st.word_ctrl[WC_MASTER] && (st.int_req || st.tx_ctrl[TXC_FORCE]));
    assign bus_out.dma_req_n = 1'b1;
    assign ser_out.ser_clk = st.ser_clk;
    assign ser_out.ser_data = st.ser_data;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    wait_states_a: assert property ((st.bus == BUS_IDLE && sel) ##1 sel [*2] |=> st.ack)
        else $error("ack not given after the inserted wait states");
    ack_single_a: assert property (st.ack |=> !st.ack && st.bus == BUS_HOLD)
        else $error("ack lasted more than one cycle");
    read_hold_a: assert property (st.oe && sel |=> st.oe)
        else $error("read data dropped while select held");
    write_end_a: assert property ((st.ack && !st.oe) |-> sel ##1 !st.oe)
        else $error("write cycle not ended locally");
    clk_low_phase_a: assert property (!st.ser_clk |->
                                      st.tx == TX_SHIFT && st.phase == PH_LOW)
        else $error("serial clock low outside the low quarter");
    data_edge_a: assert property ($changed(st.ser_data) |-> st.phase == PH_DATA && st.ser_clk)
        else $error("transmit data moved near the sampling edge");
    lsb_first_a: assert property ((emit && st.tx_bits != WORD_BITS) |=>
                                  st.ser_data == $past(st.tx_sh[0]))
        else $error("transmit bit order wrong");
    tx_hold_a: assert property ((st.tx == TX_IDLE && !st.tx_ctrl[TXC_START]) |=>
                                st.tx == TX_IDLE)
        else $error("transmit began without start");
    tx_clear_a: assert property ((st.tx == TX_SHIFT && next_st.tx == TX_IDLE) |=>
                                 !st.tx_ctrl[TXC_START] && st.status[STS_TX])
        else $error("transmit start not cleared at message end");
    gap_seen_a: assert property ((st.rx == RX_GAP ##1 st.rx == RX_BITS) |->
                                 $past(st.gap_cnt) > st.gap)
        else $error("receiver armed before the gap elapsed");
    rx_autoclr_a: assert property ((st.rx == RX_BITS && next_st.rx == RX_IDLE
                                    && st.rx_ctrl[RXC_AUTOCLR]) |=> !st.rx_ctrl[RXC_START])
        else $error("receive start not auto-cleared");
    overrun_a: assert property ((rx_push && st.rx == RX_BITS && fs.rx_full) |=>
                                st.status[STS_OVR])
        else $error("over-run not flagged");
    sticky_par_a: assert property ((st.status[STS_PAR] && !stat_clr[STS_PAR]) |=> st.status[STS_PAR])
        else $error("parity flag lost without a clear");

    tx_msg_c: cover property (st.tx == TX_SHIFT && st.tx_second ##1 st.tx == TX_IDLE);
    rx_msg_c: cover property (st.rx == RX_BITS && ev[STS_RX]);
    read_cycle_c: cover property (st.ack && st.oe ##1 st.oe [*2]);
    irq_c: cover property ($fell(bus_out.int_req_n));
endmodule

/* remote_serial_model.sv */
// remote serial equipment: gated clock frame source and transmit capture
`timescale 1ns/10ps
module remote_serial_model import serial_link_pkg::*; (
    input wire serial_out_t ser_out,
    output logic link_clock = 1'b1,
    output logic link_data = 1'b0
);
    logic [33:0] got;
    int n_got = 0;
    always @(posedge ser_out.ser_clk) begin
        got = {ser_out.ser_data, got[33:1]};
        n_got++;
    end
    // clock stands high between frames; data flips after hold so stale bits never match
    task automatic send(input logic [16:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            link_clock = 1'b0;
            link_data = bits[i];
            #24 link_clock = 1'b1;
            #24 link_data = ~link_data;
        end
    endtask
endmodule

/* tb.sv */
// self-checking bench for the gated clock serial link
`timescale 1ns/10ps
module tb import serial_link_pkg::*;;
    logic clock = 1'b0;
    logic rst = 1'b1;
    ip_bus_in_t bus_in = {5'h1f, 24'h00_0000};
    ip_bus_out_t bus_out;
    serial_out_t ser_out;
    logic link_clock, link_data;
    logic [15:0] rd;
    int error_cnt = 0, n_compared = 0, cyc = 0;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
    always #2.5 clock = ~clock;
    gated_clock_serial_link u_gated_clock_serial_link (.clock(clock), .rst(rst),
        .bus_in(bus_in), .bus_out(bus_out), .rx_link_clock(link_clock),
        .rx_data(link_data), .ser_out(ser_out));
    remote_serial_model u_remote_serial_model (.ser_out(ser_out), .link_clock(link_clock),
        .link_data(link_data));
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // selects {io,id,mem,int}; held until the edge after ack, then released
    task automatic bus(input logic [3:0] sel, input logic wr, input logic [6:0] ofs,
            input logic [15:0] wd);
        int t;
        t = 0;
        @(negedge clock);
        bus_in = {sel, ~wr, 2'h0, ofs[6:1], wd};
        while (bus_out.ack_n !== 1'b0 && t < 20) begin
            @(negedge clock);
            t++;
        end
        rd = bus_out.rdata;
        @(negedge clock);
        bus_in[28:25] = 4'hf;
        @(negedge clock);
    endtask
    task automatic wr(input logic [6:0] o, input logic [15:0] d);
        bus(4'h7, 1'b1, o, d);
    endtask
    task automatic rdr(input logic [6:0] o);
        bus(4'h7, 1'b0, o, 16'h0000);
    endtask
    task automatic t_reset();
        rdr(OFS_WORD_CTRL);
        `CHK(rd, WORD_CTRL_RESET)
        rdr(OFS_GAP);
        `CHK(rd, GAP_RESET)
        bus(4'hb, 1'b0, 7'h00, 16'h0000);
        `CHK(rd, ID_WORD)
        `CHK(bus_out.dma_req_n, 1'b1)
        `CHK(bus_out.int_req_n, 1'b1)
    endtask
    task automatic t_tx();
        wr(OFS_RX_CTRL, 16'h0080);
        wr(OFS_TX_FIFO, 16'h0102);
        repeat (100) @(negedge clock);
        `CHK(u_remote_serial_model.n_got, 0)
        wr(OFS_TX_CTRL, 16'h0041);
        rd = 16'h0001;
        for (int i = 0; i < 40 && rd[0] !== 1'b0; i++)
            rdr(OFS_TX_CTRL);
        `CHK(rd[0], 1'b0)
        `CHK(u_remote_serial_model.got[33:17], {1'b1, 16'h0102})
        `CHK(u_remote_serial_model.n_got, 17)
        wr(OFS_RX_LOOP, 16'h1234);
        rdr(OFS_RX_FIFO);
        `CHK(rd, 16'h1234)
    endtask
    task automatic t_rx();
        wr(OFS_GAP, 16'h0010);
        wr(OFS_RX_CTRL, 16'h0091);
        repeat (30) @(negedge clock);
        u_remote_serial_model.send({1'b0, 16'ha5c3}, 17);
        repeat (20) @(negedge clock);
        rdr(OFS_RX_FIFO);
        `CHK(rd, 16'ha5c3)
        rdr(OFS_STAT1);
        `CHK({rd[5:4], rd[1]}, 3'h1)
        rdr(OFS_RX_CTRL);
        `CHK(rd[0], 1'b0)
        wr(OFS_RX_CTRL, 16'h0081);
        repeat (30) @(negedge clock);
        u_remote_serial_model.send({1'b1, 16'ha5c3}, 17);
        repeat (20) @(negedge clock);
        rdr(OFS_STAT1);
        `CHK(rd[4], 1'b1)
        rdr(OFS_RX_CTRL);
        `CHK(rd[0], 1'b1)
        wr(OFS_STAT1, 16'h0010);
        rdr(OFS_STAT1);
        `CHK(rd[4], 1'b0)
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        // link-side reset needs a few link edges while rst is high
        u_remote_serial_model.send(17'h0_0000, 3);
        repeat (5) @(negedge clock);
        rst = 1'b0;
        // two idle link edges let the link-side reset synchroniser clear before a frame
        u_remote_serial_model.send(17'h0_0000, 2);
        u_remote_serial_model.n_got = 0;
        t_reset();
        t_tx();
        t_rx();
        final_report();
    end
endmodule
